// *** core/rtc_time_regs.sv ***
// clock and calendar counters with their register port
// assumes the serial interface raises accessBusy for a whole access and
// presents single-cycle read and write strobes through regReq
`timescale 1ns/10ps
module rtc_time_regs
	import rtc_pkg::*;
#(
	parameter int STABLE_CYC = OSC_STABLE_CYC,
	parameter int DIV_CYC = SEC_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// register port
	input wire rtc_req_s regReq,
	input wire logic accessBusy,
	output logic [7:0] regRdData,
	// configuration
	input wire logic hourMode12,
	// oscillator
	input wire logic crystalRunning,
	// status
	output logic oscHaltFlag,
	output logic oscGood
);

	rtc_time_s tm;
	rtc_time_s next_tm;
	logic [7:0] scratch;
	logic oscHalt;
	logic pending;
	logic secTick;

	// increment of a two-digit BCD value
	function automatic logic [7:0] bcdInc(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		if (v[3:0] == 4'h9) r = {v[7:4] + 4'h1, 4'h0};
		else r = {v[7:4], v[3:0] + 4'h1};
		return r;
	endfunction : bcdInc

	// leap when the BCD year is a multiple of four
	function automatic logic isLeap(input logic [7:0] y);
		logic r;
		r = 1'b0;
		if (!y[4]) r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
		else r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
		return r;
	endfunction : isLeap

	// last BCD day of the given month
	function automatic logic [7:0] lastDay(input logic [7:0] m, input logic lp);
		logic [7:0] r;
		r = 8'h31;
		case (m)
			8'h02: r = lp ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
			default: r = 8'h31;
		endcase
		return r;
	endfunction : lastDay

	rtc_osc_mon #(
		.STABLE_CYC(STABLE_CYC)
	) u_osc (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.crystalRunning(crystalRunning),
		.oscGood(oscGood)
	);

	rtc_sec_div #(
		.DIV_CYC(DIV_CYC)
	) u_div (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.en(oscGood),
		.secTick(secTick)
	);

	// write decode
	wire wrScratch = regReq.wrEn && (regReq.addr == ADDR_SCRATCH);
	wire wrSec = regReq.wrEn && (regReq.addr == ADDR_SECONDS);
	wire wrMin = regReq.wrEn && (regReq.addr == ADDR_MINUTES);
	wire wrHour = regReq.wrEn && (regReq.addr == ADDR_HOURS);
	wire wrDay = regReq.wrEn && (regReq.addr == ADDR_DAYS);
	wire wrWday = regReq.wrEn && (regReq.addr == ADDR_WEEKDAYS);
	wire wrMonth = regReq.wrEn && (regReq.addr == ADDR_MONTHS);
	wire wrYear = regReq.wrEn && (regReq.addr == ADDR_YEARS);
	wire anyTimeWr = wrSec || wrMin || wrHour || wrDay || wrWday ||
		wrMonth || wrYear;

	// a tick is applied only outside an access
	wire doTick = !accessBusy && (secTick || pending);

	// carry chain
	wire secWrap = (tm.sec == 8'h59);
	wire minWrap = (tm.min == 8'h59);
	wire [7:0] hour12 = {3'b000, tm.hour[4:0]};
	wire pmNow = tm.hour[HALF_DAY_POS];
	wire hourWrap = hourMode12 ? (pmNow && hour12 == 8'h11) :
		(tm.hour == 8'h23);
	wire dayWrap = (tm.day == lastDay(tm.month, isLeap(tm.year)));
	wire monthWrap = (tm.month == 8'h12);
	wire minStep = doTick && secWrap;
	wire hourStep = minStep && minWrap;
	wire dayStep = hourStep && hourWrap;
	wire monthStep = dayStep && dayWrap;
	wire yearStep = monthStep && monthWrap;

	// next hour in the chosen format
	wire [7:0] hourInc12 = (hour12 == 8'h12) ? 8'h01 :
		(hour12 == 8'h11) ? 8'h12 : bcdInc(hour12);
	wire flipHalf = (hour12 == 8'h11);
	wire [7:0] hourNext12 = {2'b00, pmNow ^ flipHalf, hourInc12[4:0]};
	wire [7:0] hourNext24 = (tm.hour == 8'h23) ? 8'h00 :
		bcdInc(tm.hour);
	wire [7:0] hourNext = hourMode12 ? hourNext12 : hourNext24;

	// counters advance with carries; a register write takes precedence
	always_comb begin
		next_tm = tm;
		if (doTick) next_tm.sec = secWrap ? 8'h00 : bcdInc(tm.sec);
		if (minStep) next_tm.min = minWrap ? 8'h00 : bcdInc(tm.min);
		if (hourStep) next_tm.hour = hourNext;
		if (dayStep) begin
			next_tm.day = dayWrap ? 8'h01 : bcdInc(tm.day);
			next_tm.wday = (tm.wday == 8'h06) ? 8'h00 : tm.wday + 8'h01;
		end
		if (monthStep) next_tm.month = monthWrap ? 8'h01 : bcdInc(tm.month);
		if (yearStep) next_tm.year = (tm.year == 8'h99) ? 8'h00 :
			bcdInc(tm.year);
		if (wrSec) next_tm.sec = regReq.data & MASK_SECONDS;
		if (wrMin) next_tm.min = regReq.data & MASK_MINUTES;
		if (wrHour) next_tm.hour = regReq.data & MASK_HOURS;
		if (wrDay) next_tm.day = regReq.data & MASK_DAYS;
		if (wrWday) next_tm.wday = regReq.data & MASK_WEEKDAYS;
		if (wrMonth) next_tm.month = regReq.data & MASK_MONTHS;
		if (wrYear) next_tm.year = regReq.data & MASK_YEARS;
	end

	// stopped oscillator sets the flag and beats any clear
	wire next_oscHalt = !oscGood ? 1'b1 :
		(wrSec ? regReq.data[OSC_HALT_POS] : oscHalt);

	// at most one tick stored while the counters are frozen
	wire next_pending = accessBusy && (pending || secTick);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tm <= {RST_SECONDS, RST_MINUTES, RST_HOURS, RST_DAYS,
				RST_WEEKDAYS, RST_MONTHS, RST_YEARS};
			oscHalt <= RST_OSC_HALT;
			pending <= 1'b0;
		end else begin
			tm <= next_tm;
			oscHalt <= next_oscHalt;
			pending <= next_pending;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) scratch <= RST_SCRATCH;
		else if (wrScratch) scratch <= regReq.data;
	end

	// read selection; unused bits read zero
	logic [7:0] rdSel;
	always_comb begin
		case (regReq.addr)
			ADDR_SCRATCH: rdSel = scratch;
			ADDR_SECONDS: rdSel = {oscHalt, tm.sec[6:0]};
			ADDR_MINUTES: rdSel = tm.min & MASK_MINUTES;
			ADDR_HOURS: rdSel = tm.hour & MASK_HOURS;
			ADDR_DAYS: rdSel = tm.day & MASK_DAYS;
			ADDR_WEEKDAYS: rdSel = tm.wday & MASK_WEEKDAYS;
			ADDR_MONTHS: rdSel = tm.month & MASK_MONTHS;
			ADDR_YEARS: rdSel = tm.year;
			default: rdSel = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) regRdData <= 8'h00;
		else if (regReq.rdEn) regRdData <= rdSel;
	end

	assign oscHaltFlag = oscHalt;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	chk_scratch_readback: assert property (
		regReq.rdEn && regReq.addr == ADDR_SCRATCH |=>
			regRdData == $past(scratch))
		else $error("scratch byte did not read back");

	chk_scratch_write: assert property (
		wrScratch |=> scratch == $past(regReq.data))
		else $error("scratch byte write lost");

	chk_halt_while_stopped: assert property (
		!oscGood |=> oscHaltFlag)
		else $error("halt flag clear while oscillator stopped");

	chk_halt_clear_held: assert property (
		oscHaltFlag && !wrSec ##1 oscHaltFlag && !wrSec |=> oscHaltFlag)
		else $error("halt flag cleared without a write");

	chk_seconds_wrap: assert property (
		doTick && secWrap && !anyTimeWr |=> tm.sec == 8'h00 &&
			tm.min != $past(tm.min))
		else $error("seconds wrap did not carry into minutes");

	chk_frozen_counters: assert property (
		accessBusy && !anyTimeWr |=> $stable(tm))
		else $error("counters moved during an access");

	chk_pending_tick: assert property (
		pending && !accessBusy && !anyTimeWr |=>
			tm.sec != $past(tm.sec))
		else $error("stored tick not applied after access");

	chk_half_day_flip: assert property (
		hourStep && hourMode12 && hour12 == 8'h11 && !anyTimeWr |=>
			tm.hour[HALF_DAY_POS] != $past(tm.hour[HALF_DAY_POS]) &&
			tm.hour[4:0] == 5'h12)
		else $error("half-day bit did not toggle at 12");

	chk_weekday_wrap: assert property (
		dayStep && tm.wday == 8'h06 && !anyTimeWr |=> tm.wday == 8'h00)
		else $error("weekday did not wrap to 0");

	chk_leap_feb: assert property (
		dayStep && tm.month == 8'h02 && tm.day == 8'h28 &&
			isLeap(tm.year) && !anyTimeWr |=> tm.day == 8'h29)
		else $error("leap February skipped day 29");

	chk_minutes_unused: assert property (
		regReq.rdEn && regReq.addr == ADDR_MINUTES |=> !regRdData[7])
		else $error("minutes bit 7 read nonzero");

	chk_halt_readback: assert property (
		regReq.rdEn && regReq.addr == ADDR_SECONDS |=>
			regRdData[OSC_HALT_POS] == $past(oscHaltFlag))
		else $error("halt flag not at seconds bit 7");

	chk_halt_clear_ok: assert property (
		oscGood && wrSec && !regReq.data[OSC_HALT_POS] |=> !oscHaltFlag)
		else $error("halt flag clear refused while running");

	chk_no_tick_stopped: assert property (
		!oscGood |=> !secTick)
		else $error("tick while oscillator not trusted");

	chk_seconds_units: assert property (
		doTick && tm.sec[3:0] == 4'h9 && !wrSec |=> tm.sec[3:0] == 4'h0)
		else $error("seconds units did not wrap past 9");

	chk_minute_carry: assert property (
		hourStep && !anyTimeWr |=> tm.min == 8'h00)
		else $error("minutes did not wrap on hour carry");

	chk_hour24_wrap: assert property (
		hourStep && !hourMode12 && tm.hour == 8'h23 && !anyTimeWr |=>
			tm.hour == 8'h00 && tm.day != $past(tm.day))
		else $error("24-hour count did not wrap into the day");

	chk_twelve_to_one: assert property (
		hourStep && hourMode12 && tm.hour[4:0] == 5'h12 && !anyTimeWr |=>
			tm.hour[4:0] == 5'h01 &&
			tm.hour[HALF_DAY_POS] == $past(tm.hour[HALF_DAY_POS]))
		else $error("12-hour count did not step from 12 to 1");

	chk_feb_common: assert property (
		dayStep && tm.month == 8'h02 && tm.day == 8'h28 &&
			!isLeap(tm.year) && !anyTimeWr |=>
			tm.day == 8'h01 && tm.month == 8'h03)
		else $error("common February did not end after day 28");

	chk_year_end_wrap: assert property (
		dayStep && tm.month == 8'h12 && tm.day == 8'h31 && !anyTimeWr |=>
			tm.day == 8'h01 && tm.month == 8'h01)
		else $error("last day of year did not wrap to 1 January");

	chk_year_wrap: assert property (
		yearStep && tm.year == 8'h99 && !anyTimeWr |=> tm.year == 8'h00)
		else $error("year did not wrap from 99 to 00");

	chk_weekday_held: assert property (
		doTick && !dayStep && !anyTimeWr |=> $stable(tm.wday))
		else $error("weekday moved without a day carry");

	chk_pending_store: assert property (
		accessBusy && secTick |=> pending)
		else $error("tick during access was not stored");

	chk_hours_read: assert property (
		regReq.rdEn && regReq.addr == ADDR_HOURS |=> regRdData[7:6] == 2'b00)
		else $error("hours bits 7 and 6 read nonzero");

	chk_days_read: assert property (
		regReq.rdEn && regReq.addr == ADDR_DAYS |=> regRdData[7:6] == 2'b00)
		else $error("day bits 7 and 6 read nonzero");

	chk_weekday_read: assert property (
		regReq.rdEn && regReq.addr == ADDR_WEEKDAYS |=>
			regRdData[7:3] == 5'h00)
		else $error("weekday bits 7 to 3 read nonzero");

endmodule : rtc_time_regs

// *** core/rtc_pkg.sv ***
// constants, types and field layout of the clock and calendar registers
// assumes one 40 MHz system clock and a register port driven by the
// serial interface logic outside this block
package rtc_pkg;

	// register offsets
	localparam logic [7:0] ADDR_SCRATCH = 8'h03;
	localparam logic [7:0] ADDR_SECONDS = 8'h04;
	localparam logic [7:0] ADDR_MINUTES = 8'h05;
	localparam logic [7:0] ADDR_HOURS = 8'h06;
	localparam logic [7:0] ADDR_DAYS = 8'h07;
	localparam logic [7:0] ADDR_WEEKDAYS = 8'h08;
	localparam logic [7:0] ADDR_MONTHS = 8'h09;
	localparam logic [7:0] ADDR_YEARS = 8'h0A;

	// field positions and write masks
	localparam int OSC_HALT_POS = 7;
	localparam int HALF_DAY_POS = 5;
	localparam logic [7:0] MASK_SECONDS = 8'h7F;
	localparam logic [7:0] MASK_MINUTES = 8'h7F;
	localparam logic [7:0] MASK_HOURS = 8'h3F;
	localparam logic [7:0] MASK_DAYS = 8'h3F;
	localparam logic [7:0] MASK_WEEKDAYS = 8'h07;
	localparam logic [7:0] MASK_MONTHS = 8'h1F;
	localparam logic [7:0] MASK_YEARS = 8'hFF;

	// reset values
	localparam logic [7:0] RST_SCRATCH = 8'h00;
	localparam logic RST_OSC_HALT = 1'b1;
	localparam logic [7:0] RST_SECONDS = 8'h00;
	localparam logic [7:0] RST_MINUTES = 8'h00;
	localparam logic [7:0] RST_HOURS = 8'h00;
	localparam logic [7:0] RST_DAYS = 8'h01;
	localparam logic [7:0] RST_WEEKDAYS = 8'h06;
	localparam logic [7:0] RST_MONTHS = 8'h01;
	localparam logic [7:0] RST_YEARS = 8'h00;

	// timing
	localparam int CLK_HZ = 40_000_000;
	localparam int SEC_CYC = CLK_HZ;
	localparam int OSC_STABLE_MS = 200;
	localparam int OSC_STABLE_CYC = OSC_STABLE_MS * (CLK_HZ / 1000);

	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [7:0] addr;
		logic [7:0] data;
	} rtc_req_s;

	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] day;
		logic [7:0] wday;
		logic [7:0] month;
		logic [7:0] year;
	} rtc_time_s;

	typedef enum logic [2:0] {
		OSC_STOPPED = 3'b001,
		OSC_SETTLING = 3'b010,
		OSC_GOOD = 3'b100
	} rtc_osc_e;

endpackage : rtc_pkg

// *** core/rtc_osc_mon.sv ***
// oscillator monitor: decides when the crystal is running and stable
// assumes crystalRunning is an asynchronous level from the oscillator pad
`timescale 1ns/10ps
module rtc_osc_mon
	import rtc_pkg::*;
#(
	parameter int STABLE_CYC = OSC_STABLE_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// oscillator activity
	input wire logic crystalRunning,
	output logic oscGood
);

	logic syncA;
	logic syncB;
	logic [31:0] settleCnt;
	rtc_osc_e state;
	rtc_osc_e next_state;

	wire settleDone = (settleCnt == 32'(STABLE_CYC - 1));

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			syncA <= 1'b0;
			syncB <= 1'b0;
		end else begin
			syncA <= crystalRunning;
			syncB <= syncA;
		end
	end

	// any loss of activity restarts the settling wait
	always_comb begin
		next_state = state;
		case (state)
			OSC_STOPPED: if (syncB) next_state = OSC_SETTLING;
			OSC_SETTLING: begin
				if (!syncB) next_state = OSC_STOPPED;
				else if (settleDone) next_state = OSC_GOOD;
			end
			OSC_GOOD: if (!syncB) next_state = OSC_STOPPED;
			default: next_state = OSC_STOPPED;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state <= OSC_STOPPED;
			settleCnt <= 32'h0;
		end else begin
			state <= next_state;
			settleCnt <= (state == OSC_SETTLING) ? settleCnt + 32'h1 : 32'h0;
		end
	end

	assign oscGood = (state == OSC_GOOD);

endmodule : rtc_osc_mon

// *** core/rtc_sec_div.sv ***
// one-second prescaler: emits a one-cycle enable pulse once per second
// assumes en drops whenever the oscillator is not trusted
`timescale 1ns/10ps
module rtc_sec_div
	import rtc_pkg::*;
#(
	parameter int DIV_CYC = SEC_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// control and tick
	input wire logic en,
	output logic secTick
);

	logic [31:0] divCnt;

	wire divWrap = (divCnt == 32'(DIV_CYC - 1));

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			divCnt <= 32'h0;
			secTick <= 1'b0;
		end else begin
			divCnt <= (!en || divWrap) ? 32'h0 : divCnt + 32'h1;
			secTick <= en && divWrap;
		end
	end

endmodule : rtc_sec_div

// *** tb/rtc_host_model.sv ***
// host model: drives the register port as the serial logic would
// assumes clk_sys is the block's clock; requests change at its falling edge
`timescale 1ns/10ps
module rtc_host_model
	import rtc_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// register port
	output rtc_req_s regReq,
	output logic accessBusy,
	input wire logic [7:0] regRdData
);
	initial begin
		regReq = '0;
		accessBusy = 1'b0;
	end

	task automatic open_acc();
		@(negedge clk_sys);
		accessBusy = 1'b1;
	endtask : open_acc

	task automatic close_acc();
		@(negedge clk_sys);
		accessBusy = 1'b0;
	endtask : close_acc

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		regReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, data: d};
		@(negedge clk_sys);
		// released data lines do not keep the last value
		regReq = '{wrEn: 1'b0, rdEn: 1'b0, addr: a, data: ~d};
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		regReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, data: 8'h00};
		@(negedge clk_sys);
		regReq.rdEn = 1'b0;
		d = regRdData;
	endtask : rd
endmodule : rtc_host_model

// *** tb/test_rtc_time_date_registers.sv ***
// testbench of the clock and calendar registers with shortened counts
// assumes the host model drives the register port at the falling edge
`timescale 1ns/10ps
module test_rtc_time_date_registers;
	import rtc_pkg::*;
	localparam int STB = 20;
	localparam int DIV = 50;
	logic clk_sys, resetn, hourMode12, crystalRunning, oscHaltFlag, oscGood;
	logic accessBusy;
	logic [7:0] regRdData;
	rtc_req_s regReq;
	int error_cnt = 0;
	int compares = 0;

	rtc_time_regs #(.STABLE_CYC(STB), .DIV_CYC(DIV)) DUT (
		.clk_sys(clk_sys), .resetn(resetn), .regReq(regReq),
		.accessBusy(accessBusy), .regRdData(regRdData),
		.hourMode12(hourMode12), .crystalRunning(crystalRunning),
		.oscHaltFlag(oscHaltFlag), .oscGood(oscGood));
	rtc_host_model host (.clk_sys(clk_sys), .regReq(regReq),
		.accessBusy(accessBusy), .regRdData(regRdData));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// write then read back inside one access, so no tick intervenes
	task automatic wrrd(input logic [7:0] a, d, exp);
		logic [7:0] r;
		host.open_acc();
		host.wr(a, d);
		host.rd(a, r);
		host.close_acc();
		chk(r, exp);
	endtask : wrrd

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] r;
		host.open_acc();
		host.rd(a, r);
		host.close_acc();
		chk(r, exp);
	endtask : rchk

	// polls seconds until a tick has just landed
	task automatic sync_tick();
		logic [7:0] a, b;
		int n;
		host.open_acc();
		host.rd(ADDR_SECONDS, a);
		host.close_acc();
		b = a;
		n = 0;
		while (b === a && n < 200) begin
			host.open_acc();
			host.rd(ADDR_SECONDS, b);
			host.close_acc();
			n++;
		end
		if (n >= 200) begin
			error_cnt++;
			$display("ERROR at %0t: no tick, got %h held %h", $time, b, a);
		end
	endtask : sync_tick

	task automatic test_reset();
		logic [7:0] ra[9] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
			8'h09, 8'h0A, 8'h20};
		logic [7:0] rv[9] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h06,
			8'h01, 8'h00, 8'h00};
		for (int i = 0; i < 9; i++) begin
			rchk(ra[i], rv[i]);
		end
	endtask : test_reset

	task automatic test_halt();
		int n;
		wrrd(ADDR_SECONDS, 8'h00, 8'h80);
		@(negedge clk_sys);
		crystalRunning = 1'b1;
		n = 0;
		while (oscGood !== 1'b1 && n < 200) begin
			@(negedge clk_sys);
			n++;
		end
		chk(8'(n), 8'(STB + 3));
		wrrd(ADDR_SECONDS, 8'h00, 8'h00);
		chk({7'h00, oscHaltFlag}, 8'h00);
	endtask : test_halt

	task automatic test_masks();
		wrrd(ADDR_SCRATCH, 8'hA5, 8'hA5);
		wrrd(ADDR_SCRATCH, 8'hFF, 8'hFF);
		wrrd(ADDR_MINUTES, 8'hFF, 8'h7F);
		wrrd(ADDR_HOURS, 8'hFF, 8'h3F);
		wrrd(ADDR_DAYS, 8'hFF, 8'h3F);
		wrrd(ADDR_WEEKDAYS, 8'hFF, 8'h07);
		wrrd(8'h20, 8'h5A, 8'h00);
	endtask : test_masks

	task automatic test_roll(input logic m12, input logic [7:0] hr, dy, mo,
		yr, eh, ed, em, ey);
		logic [7:0] r[6];
		@(negedge clk_sys);
		hourMode12 = m12;
		host.open_acc();
		host.wr(ADDR_SECONDS, 8'h59);
		host.wr(ADDR_MINUTES, 8'h59);
		host.wr(ADDR_HOURS, hr);
		host.wr(ADDR_DAYS, dy);
		host.wr(ADDR_WEEKDAYS, 8'h06);
		host.wr(ADDR_MONTHS, mo);
		host.wr(ADDR_YEARS, yr);
		host.close_acc();
		sync_tick();
		host.open_acc();
		for (int i = 0; i < 6; i++) begin
			host.rd(ADDR_MINUTES + 8'(i), r[i]);
		end
		host.close_acc();
		chk(r[0], 8'h00);
		chk(r[1], eh);
		chk(r[2], ed);
		chk(r[3], (ed !== dy) ? 8'h00 : 8'h06);
		chk(r[4], em);
		chk(r[5], ey);
	endtask : test_roll

	task automatic test_freeze();
		sync_tick();
		host.open_acc();
		host.wr(ADDR_SECONDS, 8'h05);
		repeat (2 * DIV + 10) @(negedge clk_sys);
		host.close_acc();
		rchk(ADDR_SECONDS, 8'h06);
	endtask : test_freeze

	task automatic test_stop();
		int n;
		@(negedge clk_sys);
		crystalRunning = 1'b0;
		n = 0;
		while (oscHaltFlag !== 1'b1 && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
		chk({7'h00, oscHaltFlag}, 8'h01);
		wrrd(ADDR_SECONDS, 8'h00, 8'h80);
	endtask : test_stop

	task automatic finish_test();
		$display("mismatches %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test

	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		$display("ERROR at %0t: watchdog %h expected %h", $time, 1, 0);
		finish_test();
	end

	initial begin
		resetn = 1'b0;
		hourMode12 = 1'b0;
		crystalRunning = 1'b0;
		repeat (5) @(negedge clk_sys);
		resetn = 1'b1;
		test_reset();
		test_halt();
		test_masks();
		test_roll(0, 8'h23, 8'h28, 8'h02, 8'h04, 8'h00, 8'h29, 8'h02, 8'h04);
		test_roll(0, 8'h23, 8'h28, 8'h02, 8'h01, 8'h00, 8'h01, 8'h03, 8'h01);
		test_roll(0, 8'h23, 8'h31, 8'h12, 8'h99, 8'h00, 8'h01, 8'h01, 8'h00);
		test_roll(0, 8'h09, 8'h15, 8'h06, 8'h10, 8'h10, 8'h15, 8'h06, 8'h10);
		test_roll(1, 8'h11, 8'h15, 8'h06, 8'h10, 8'h32, 8'h15, 8'h06, 8'h10);
		test_roll(1, 8'h31, 8'h15, 8'h06, 8'h10, 8'h12, 8'h16, 8'h06, 8'h10);
		test_roll(1, 8'h12, 8'h15, 8'h06, 8'h10, 8'h01, 8'h15, 8'h06, 8'h10);
		test_freeze();
		test_stop();
		finish_test();
	end
endmodule : test_rtc_time_date_registers
